// >>> inc/kef_map.vh
`ifndef KEF_MAP_VH
`define KEF_MAP_VH

// Register pointer of the key event flag register.
`define KEF_KEY_FLAGS_OFS 8'h02
// Reset value of the six implemented flag bits (bits 7 down to 2).
`define KEF_KEY_FLAGS_RST 6'h00
// Lowest register bit used by the key flags (key 0 press).
`define KEF_KEY_BASE_BIT 2
// Number of keys covered by this register slice.
`define KEF_NUM_KEYS 3
// Value that unmapped pointers and unimplemented bits read as.
`define KEF_READ_ZERO 8'h00
// Seven-bit bus address of the device; the value is arbitrary.
`define KEF_DEV_ADDR 7'h3b
// Time the core needs after a read before the flags clear, in microseconds.
`define KEF_CLEAR_TIME_US 200
// Core clock rate in MHz.
`define KEF_MCLK_MHZ 200
// Clear delay in core clock cycles.
`define KEF_CLEAR_CYCLES (`KEF_CLEAR_TIME_US * `KEF_MCLK_MHZ)

`endif

// >>> verilog/kef_sync.v
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser for levels that arrive from outside the core clock domain.
module kef_sync #(
    parameter WIDTH = 2
) (
    input wire mclk, // Core clock.
    input wire rst, // Asynchronous reset, active high.
    input wire ce, // Clock enable; state holds while low.
    input wire [WIDTH-1:0] async_in, // Unsynchronised inputs.
    output wire [WIDTH-1:0] sync_out // Synchronised outputs.
);

    reg [WIDTH-1:0] meta_r; // First stage, read only by the second stage.
    reg [WIDTH-1:0] sync_r; // Second stage.

    // Both stages idle high, matching the bus lines at rest.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= {WIDTH{1'b1}};
            sync_r <= {WIDTH{1'b1}};
        end
        else if (ce)
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule // kef_sync

`default_nettype wire

// >>> verilog/kef_flags.v
`timescale 1ns/10ps
`default_nettype none
`include "kef_map.vh"

module kef_flags #(
    parameter NKEYS = `KEF_NUM_KEYS,
    parameter CLEAR_CYCLES = `KEF_CLEAR_CYCLES,
    parameter [6:0] DEV_ADDR = `KEF_DEV_ADDR
) (
    input wire mclk, // Core clock, 200 MHz.
    input wire rst, // Asynchronous reset, active high.
    input wire ce, // Clock enable; all state holds while low.
    input wire [NKEYS-1:0] press_qual, // Press qualified by press_qualify_timer, per key.
    input wire [NKEYS-1:0] release_qual, // Release qualified by release_qualify_timer, per key.
    input wire key_detect_enable, // Key detection enable setting.
    input wire accessory_removed, // One-cycle pulse on accessory removal.
    input wire scl_in, // Bus clock pin.
    input wire sda_in, // Bus data pin, input side.
    output wire sda_o, // Bus data pin, output value.
    output reg sda_oe, // Bus data pin, high while driven low.
    output reg int_n, // Interrupt output, active low.
    output wire [2*NKEYS-1:0] flags // Current flag bits 7 down to 2.
);

    localparam NF = 2 * NKEYS;
    // The clear delay counter is 16 bits wide; the full parameter is cut to it on purpose.
    localparam [31:0] CLR_FULL = CLEAR_CYCLES;
    localparam [15:0] CLR_LOAD = CLR_FULL[15:0];
    // Bus engine states.
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_ACKA = 3'd2;
    localparam [2:0] ST_WDAT = 3'd3;
    localparam [2:0] ST_ACKW = 3'd4;
    localparam [2:0] ST_RDAT = 3'd5;
    localparam [2:0] ST_RACK = 3'd6;

    wire scl_s; // Synchronised bus clock.
    wire sda_s; // Synchronised bus data.
    reg scl_d; // Previous synchronised bus clock.
    reg sda_d; // Previous synchronised bus data.
    reg [NF-1:0] flag_r; // Event flags, bit 0 is register bit 2.
    wire [NF-1:0] flag_nxt; // Next value of the flags.
    reg [NKEYS-1:0] press_d; // Previous press qualification levels.
    reg [NKEYS-1:0] rel_d; // Previous release qualification levels.
    reg en_d; // Enable as seen last cycle.
    reg [2:0] state_r; // Bus engine state.
    reg [3:0] bit_r; // Bits moved in the current byte.
    reg [7:0] shift_r; // Shift register for both directions.
    reg [7:0] ptr_r; // Register pointer.
    reg rw_r; // High for a read transfer.
    reg [NF-1:0] snap_r; // Flag bits presented in the byte being read.
    reg [NF-1:0] pend_r; // Flag bits waiting for the delayed clear.
    reg [15:0] clr_cnt_r; // Delay count before the clear.
    reg [NF-1:0] clr_mask; // Bits cleared this cycle.
    reg flush; // Whole-register clear this cycle.
    reg rd_done; // A read of the flag register finished this cycle.

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_c = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c = scl_s & scl_d & ~sda_d & sda_s;

    kef_sync #(
        .WIDTH(2)
    ) u_sync (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .async_in({scl_in, sda_in}),
        .sync_out({scl_s, sda_s})
    );

    // The pin is only ever pulled low, so the data value is a constant zero.
    assign sda_o = 1'b0;
    assign flags = flag_r;

    // Any removal or a low enable empties the register; removal itself stands for the enable being forced low.
    always @*
    begin
        flush = ~key_detect_enable | accessory_removed;
        clr_mask = {NF{1'b0}};
        if (pend_r != {NF{1'b0}} && clr_cnt_r == 16'h0000)
        begin
            clr_mask = pend_r;
        end
    end

    // Per key, set follows a rising qualified level only, so a held key raises one event.
    genvar k;
    generate
        for (k = 0; k < NKEYS; k = k + 1)
        begin : g_key
            wire p_set = press_qual[k] & ~press_d[k] & key_detect_enable & en_d;
            wire r_set = release_qual[k] & ~rel_d[k] & key_detect_enable & en_d;
            // A set beats a read clear landing in the same cycle, but a flush beats both.
            assign flag_nxt[2*k] = ~flush & (p_set | (flag_r[2*k] & ~clr_mask[2*k]));
            // A fresh press wipes the stale release of the same key.
            assign flag_nxt[2*k+1] = ~flush & (r_set | (flag_r[2*k+1] & ~clr_mask[2*k+1] & ~p_set));
        end
    endgenerate

    // Flag storage, edge history and interrupt pin.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            flag_r <= `KEF_KEY_FLAGS_RST;
            press_d <= {NKEYS{1'b0}};
            rel_d <= {NKEYS{1'b0}};
            en_d <= 1'b0;
            int_n <= 1'b1;
        end
        else if (ce)
        begin
            flag_r <= flag_nxt;
            press_d <= press_qual;
            rel_d <= release_qual;
            en_d <= key_detect_enable;
            // Key events are not subject to the conversion interrupt mask.
            int_n <= ~(|flag_nxt);
        end
    end

    // Delayed clear: the read bits are dropped a fixed time after the read, not at once.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pend_r <= {NF{1'b0}};
            clr_cnt_r <= 16'h0000;
        end
        else if (ce)
        begin
            if (flush)
            begin
                pend_r <= {NF{1'b0}};
                clr_cnt_r <= 16'h0000;
            end
            else if (rd_done)
            begin
                // A second read restarts the wait and widens the set of bits to clear.
                pend_r <= (clr_mask != {NF{1'b0}}) ? snap_r : (pend_r | snap_r);
                clr_cnt_r <= CLR_LOAD - 16'h0001;
            end
            else if (clr_mask != {NF{1'b0}})
            begin
                pend_r <= {NF{1'b0}};
            end
            else if (clr_cnt_r != 16'h0000)
            begin
                clr_cnt_r <= clr_cnt_r - 16'h0001;
            end
        end
    end

    // Completion of a read byte of the flag register, taken at the acknowledge clock's falling edge.
    always @*
    begin
        rd_done = (state_r == ST_RACK) && scl_fall && (ptr_r == `KEF_KEY_FLAGS_OFS) && !start_c && !stop_c;
    end

    // Bus engine: address, one pointer byte on writes, data bytes on reads. No clock stretching.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            state_r <= ST_IDLE;
            bit_r <= 4'h0;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            snap_r <= {NF{1'b0}};
            sda_oe <= 1'b0;
        end
        else if (ce)
        begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            if (start_c)
            begin
                state_r <= ST_ADDR;
                bit_r <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (stop_c)
            begin
                state_r <= ST_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_WDAT:
                    begin
                        if (scl_rise && bit_r != 4'h8)
                        begin
                            shift_r <= {shift_r[6:0], sda_s};
                            bit_r <= bit_r + 4'h1;
                        end
                        else if (scl_fall && bit_r == 4'h8)
                        begin
                            bit_r <= 4'h0;
                            if (state_r == ST_WDAT)
                            begin
                                ptr_r <= shift_r;
                                state_r <= ST_ACKW;
                                sda_oe <= 1'b1;
                            end
                            else if (shift_r[7:1] == DEV_ADDR)
                            begin
                                rw_r <= shift_r[0];
                                state_r <= ST_ACKA;
                                sda_oe <= 1'b1;
                            end
                            else
                            begin
                                // Another device's address: stay off the bus until the next start.
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACKA, ST_ACKW:
                    begin
                        if (scl_fall)
                        begin
                            if (state_r == ST_ACKA && rw_r)
                            begin
                                // Only the flag register is modelled; other pointers read zero.
                                if (ptr_r == `KEF_KEY_FLAGS_OFS)
                                begin
                                    shift_r <= {flag_r, 2'b00};
                                    snap_r <= flag_r;
                                    sda_oe <= ~flag_r[NF-1];
                                end
                                else
                                begin
                                    shift_r <= `KEF_READ_ZERO;
                                    snap_r <= {NF{1'b0}};
                                    sda_oe <= 1'b1;
                                end
                                bit_r <= 4'h1;
                                state_r <= ST_RDAT;
                            end
                            else
                            begin
                                // Writes carry a pointer only; further bytes simply overwrite it.
                                sda_oe <= 1'b0;
                                state_r <= ST_WDAT;
                            end
                        end
                    end
                    ST_RDAT:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_r == 4'h8)
                            begin
                                sda_oe <= 1'b0;
                                state_r <= ST_RACK;
                            end
                            else
                            begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sda_oe <= ~shift_r[6];
                                bit_r <= bit_r + 4'h1;
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_rise)
                        begin
                            rw_r <= ~sda_s;
                        end
                        else if (scl_fall)
                        begin
                            if (rw_r)
                            begin
                                // Controller acknowledged: present freshly sampled flags, minus the bits sent in the previous byte.
                                if (ptr_r == `KEF_KEY_FLAGS_OFS)
                                begin
                                    shift_r <= {flag_nxt & ~snap_r, 2'b00};
                                    snap_r <= flag_nxt & ~snap_r;
                                    sda_oe <= ~(flag_nxt[NF-1] & ~snap_r[NF-1]);
                                end
                                else
                                begin
                                    shift_r <= `KEF_READ_ZERO;
                                    sda_oe <= 1'b1;
                                end
                                bit_r <= 4'h1;
                                state_r <= ST_RDAT;
                            end
                            else
                            begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    default:
                    begin
                        state_r <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // kef_flags

`default_nettype wire

// >>> verif/kef_flags_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the flag register at its ports.
module kef_flags_asserts #(
    parameter NKEYS = 3,
    parameter CLEAR_CYCLES = 20
) (
    input wire logic mclk, // Core clock.
    input wire logic rst, // Reset.
    input wire logic ce, // Clock enable.
    input wire logic [NKEYS-1:0] press_qual, // Press levels.
    input wire logic [NKEYS-1:0] release_qual, // Release levels.
    input wire logic key_detect_enable, // Detect enable.
    input wire logic accessory_removed, // Removal pulse.
    input wire logic scl_in, // Bus clock.
    input wire logic sda_o, // Data value.
    input wire logic sda_oe, // Data drive.
    input wire logic int_n, // Interrupt.
    input wire logic [2*NKEYS-1:0] flags // Flag bits.
);
    logic en_prev_r; // Enable one cycle ago.
    logic armed; // Key edges count only here.
    // Edges in the first enabled cycle are ignored, so the old level is kept.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            en_prev_r <= 1'b0;
        else
            en_prev_r <= key_detect_enable;
    end
    assign armed = ce && key_detect_enable && en_prev_r && !accessory_removed;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // A flush leaves nothing set on the next cycle.
    sequence s_all_clear;
        ##1 !(|flags);
    endsequence
    a_press_sets: assert property ($rose(press_qual[0]) && armed |=> flags[0])
        else $error("press flag not set");
    a_release_sets: assert property ($rose(release_qual[2]) && armed |=> flags[5])
        else $error("release flag not set");
    a_press_edge_only: assert property ($rose(flags[0]) |-> $past(press_qual[0]) && !$past(press_qual[0], 2))
        else $error("press flag without edge");
    a_release_edge_only: assert property ($rose(flags[5]) |-> $past(release_qual[2]) && !$past(release_qual[2], 2))
        else $error("release flag without edge");
    a_flush_clears: assert property (ce && (!key_detect_enable || accessory_removed) |-> s_all_clear)
        else $error("flags survive flush");
    a_press_supersedes: assert property ($rose(press_qual[1]) && armed && !$rose(release_qual[1]) |=> !flags[3])
        else $error("release flag kept");
    a_int_tracks: assert property (int_n == !(|flags))
        else $error("interrupt disagrees with flags");
    a_sda_quiet_high: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data moved while clock high");
endmodule // kef_flags_asserts
bind kef_flags kef_flags_asserts #(.NKEYS(NKEYS), .CLEAR_CYCLES(CLEAR_CYCLES)) u_chk (.mclk(mclk), .rst(rst),
    .ce(ce), .press_qual(press_qual), .release_qual(release_qual), .key_detect_enable(key_detect_enable),
    .accessory_removed(accessory_removed), .scl_in(scl_in), .sda_o(sda_o), .sda_oe(sda_oe), .int_n(int_n),
    .flags(flags));
`default_nettype wire

// >>> verif/kef_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host bus controller; the data line has a pull-up, so release reads high.
module kef_host_model (
    output logic scl, // Bus clock, 64 ns period in frames.
    output logic sda_pull, // High while the host pulls data low.
    input wire logic sda // Resolved data line.
);
    // Clock idles high and stands still between frames.
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Waits first so the device can let go of an acknowledge.
    task automatic start();
        sda_pull = 1'b0;
        #16 scl = 1'b1;
        #16 sda_pull = 1'b1;
        #16 scl = 1'b0;
        #16;
    endtask
    // Data rises while the clock is high.
    task automatic stop();
        sda_pull = 1'b1;
        #16 scl = 1'b1;
        #16 sda_pull = 1'b0;
        #16;
    endtask
    // Data only changes while the clock is low.
    task automatic bit_out(input logic b);
        sda_pull = ~b;
        #16 scl = 1'b1;
        #32 scl = 1'b0;
        #16;
    endtask
    // Samples in the middle of the high phase.
    task automatic bit_in(output logic b);
        sda_pull = 1'b0;
        #16 scl = 1'b1;
        #16 b = sda;
        #16 scl = 1'b0;
        #16;
    endtask
    // Sends a byte MSB first and returns the acknowledge.
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(a);
        ack = ~a;
    endtask
    // Takes a byte; last makes the host answer with a not-acknowledge.
    task automatic get_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            bit_in(d[i]);
        bit_out(last);
    endtask
endmodule // kef_host_model
`default_nettype wire

// >>> verif/key_event_flag_register_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "kef_map.vh"
// Key events and host reads against the flag register.
module key_event_flag_register_bench;
    localparam CLR = 20; // Shortened read-clear delay.
    logic mclk = 1'b0; // Core clock.
    logic rst = 1'b1; // Reset.
    logic [2:0] press_qual = 3'h0; // Press levels.
    logic [2:0] release_qual = 3'h0; // Release levels.
    logic key_detect_enable = 1'b1; // Detect enable.
    logic accessory_removed = 1'b0; // Removal pulse.
    wire scl; // Host bus clock.
    wire host_pull; // Host pulls data low.
    wire sda_o; // Device data value.
    wire sda_oe; // Device pulls data low.
    wire int_n; // Interrupt.
    wire [5:0] flags; // Flag bits.
    wire sda = ~(host_pull | sda_oe); // Open-drain line with pull-up.
    integer n_fail = 0; // Mismatches.
    integer total_checks = 0; // Comparisons.
    logic [7:0] rd; // Read data.
    logic ack; // Acknowledge.
    always #2.5 mclk = ~mclk;
    kef_flags #(.CLEAR_CYCLES(CLR)) DUT (.mclk(mclk), .rst(rst), .ce(1'b1), .press_qual(press_qual),
        .release_qual(release_qual), .key_detect_enable(key_detect_enable), .accessory_removed(accessory_removed),
        .scl_in(scl), .sda_in(sda), .sda_o(sda_o), .sda_oe(sda_oe), .int_n(int_n), .flags(flags));
    kef_host_model HOST (.scl(scl), .sda_pull(host_pull), .sda(sda));
    // Counts a comparison and reports a mismatch.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Pointer write, repeated start, one-byte read.
    task automatic reg_read(input logic [7:0] ptr, output logic [7:0] d);
        HOST.start();
        HOST.put_byte({`KEF_DEV_ADDR, 1'b0}, ack);
        HOST.put_byte(ptr, ack);
        HOST.start();
        HOST.put_byte({`KEF_DEV_ADDR, 1'b1}, ack);
        chk({7'h00, ack}, 8'h01);
        HOST.get_byte(1'b1, d);
        HOST.stop();
    endtask
    // Lets edges pass and settles past them.
    task automatic tick(input integer n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Verdict and end of run.
    task automatic final_report();
        if (n_fail == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence.
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        tick(6);
        reg_read(`KEF_KEY_FLAGS_OFS, rd);
        chk(rd, 8'h00);
        reg_read(8'h03, rd);
        chk(rd, 8'h00);
        @(posedge mclk) press_qual <= 3'h7;
        tick(3);
        chk({2'h0, flags}, 8'h15);
        chk({7'h00, int_n}, 8'h00);
        reg_read(`KEF_KEY_FLAGS_OFS, rd);
        chk(rd, 8'h54);
        chk({2'h0, flags}, 8'h15);
        chk({7'h00, sda_o}, 8'h00);
        tick(CLR + 10);
        reg_read(`KEF_KEY_FLAGS_OFS, rd);
        chk(rd, 8'h00);
        @(posedge mclk)
        begin
            press_qual <= 3'h0;
            release_qual <= 3'h7;
        end
        tick(3);
        chk({2'h0, flags}, 8'h2a);
        @(posedge mclk) press_qual <= 3'h2;
        tick(3);
        chk({2'h0, flags}, 8'h26);
        @(posedge mclk) key_detect_enable <= 1'b0;
        tick(3);
        chk({2'h0, flags}, 8'h00);
        chk({7'h00, int_n}, 8'h01);
        @(posedge mclk) key_detect_enable <= 1'b1;
        tick(3);
        @(posedge mclk) press_qual <= 3'h7;
        tick(3);
        chk({2'h0, flags}, 8'h11);
        @(posedge mclk) accessory_removed <= 1'b1;
        @(posedge mclk) accessory_removed <= 1'b0;
        tick(2);
        chk({2'h0, flags}, 8'h00);
        HOST.start();
        HOST.put_byte(8'h20, ack);
        HOST.stop();
        chk({7'h00, ack}, 8'h00);
        final_report();
    end
    // Cuts a hang short.
    initial
    begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule // key_event_flag_register_bench
`default_nettype wire
